// [drive_pkg.sv]
// Shared constants for the drive mode-select block
package drive_pkg;
    // Clock and filter sampling
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned FILT_SAMPLE_NS = 1000;
    localparam int unsigned FILT_SAMPLE_CYC = FILT_SAMPLE_NS / CLK_PERIOD_NS;
    localparam int unsigned REF_W = 12;
    localparam int unsigned PRM_W = 16;
    // Parameter numbers
    localparam logic [7:0] PRM_FILT = 8'h4A;
    localparam logic [7:0] PRM_RSTSEL = 8'h4B;
    localparam logic [7:0] PRM_ALMSEL = 8'h4C;
    localparam logic [7:0] PRM_WPROT = 8'h4D;
    localparam logic [7:0] PRM_DIRINH = 8'h4E;
    localparam logic [7:0] PRM_OPSRC = 8'h4F;
    localparam logic [7:0] PRM_MCAP = 8'h50;
    localparam logic [7:0] PRM_POLES = 8'h51;
    localparam logic [7:0] PRM_MON_LO = 8'h33;
    localparam logic [7:0] PRM_MON_HI = 8'h38;
    localparam int unsigned PRM_CNT = 8;
    // Parameter reset values
    localparam logic [15:0] RST_FILT = 16'h0001;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0C;
    localparam logic [7:0] REG_PRM = 8'h20;
    // Field positions
    localparam int unsigned CTRL_EXT = 0;
    localparam int unsigned EV_REFUSED = 0;
    localparam int unsigned EV_KP_LOSS = 1;
    localparam int unsigned EV_RESET = 2;
    localparam int unsigned EV_DIR = 3;
    localparam int unsigned EV_W = 4;
    // Operation-source settings
    localparam logic [15:0] OPS_SWITCH = 16'h0000;
    localparam logic [15:0] OPS_KEYPAD = 16'h0001;
    localparam logic [15:0] OPS_EXT = 16'h0002;
    localparam logic [15:0] OPS_KPFREQ = 16'h0003;
    localparam logic [15:0] OPS_EXTFREQ = 16'h0004;
    localparam logic [15:0] OPS_SWITCH2 = 16'h0006;

    // Pole settings that run vector control without a second function
    function automatic logic poles_plain(input logic [15:0] p);
        return p == 16'h0002 || p == 16'h0004 || p == 16'h0006;
    endfunction

    // Pole settings that fall back to V/F on the second-function input
    function automatic logic poles_dual(input logic [15:0] p);
        return p == 16'h000C || p == 16'h000E || p == 16'h0010;
    endfunction
endpackage

// [ref_filter.sv]
// First-order low-pass filter for the speed-reference input
`timescale 1ns/10ps
module ref_filter (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [drive_pkg::REF_W-1:0] ref_i,
    input wire logic [3:0] shift_i,
    output logic [drive_pkg::REF_W-1:0] ref_o
);
    import drive_pkg::*;

    typedef struct packed {
        logic [7:0] div;
        logic [27:0] acc;
    } filt_t;

    filt_t s;
    filt_t next_s;
    logic signed [28:0] diff;

    // Larger shift gives stronger noise rejection but slower response
    always_comb begin
        next_s = s;
        diff = $signed({1'b0, ref_i, 16'h0000}) - $signed({1'b0, s.acc});
        if (s.div == 8'(FILT_SAMPLE_CYC - 1)) begin
            next_s.div = 8'h00;
            next_s.acc = 28'(s.acc + 28'(diff >>> shift_i));
        end else begin
            next_s.div = 8'(s.div + 8'h01);
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign ref_o = s.acc[27:16];
endmodule // ref_filter

// [write_guard.sv]
// Decides whether a keypad parameter write may be stored
`timescale 1ns/10ps
module write_guard (
    // Request
    input wire logic [7:0] num_i,
    input wire logic [15:0] data_i,
    // Device state
    input wire logic [15:0] wprot_i,
    input wire logic running_i,
    input wire logic ext_mode_i,
    // Verdict
    output logic accept_o
);
    import drive_pkg::*;

    logic allowed;
    logic value_ok;
    logic run_locked;

    // Protection decision, external mode lock first
    always_comb begin
        run_locked = num_i == 8'h17 || num_i == 8'h30 || num_i == 8'h31 ||
            num_i == 8'h3C || num_i == 8'h42 || num_i == 8'h47 ||
            (num_i >= PRM_OPSRC && num_i <= PRM_POLES);
        if (ext_mode_i) begin
            allowed = num_i == PRM_OPSRC;
        end else if (num_i >= PRM_MON_LO && num_i <= PRM_MON_HI) begin
            allowed = 1'b1;
        end else begin
            case (wprot_i)
                16'h0000: allowed = !running_i;
                16'h0001: allowed = num_i == PRM_WPROT || num_i == PRM_OPSRC;
                16'h0002: allowed = !(running_i && run_locked);
                default: allowed = 1'b0;
            endcase
        end
    end

    // Value range of the settings held in this block
    always_comb begin
        case (num_i)
            PRM_RSTSEL: value_ok = data_i <= 16'h0003;
            PRM_ALMSEL, PRM_WPROT, PRM_DIRINH: value_ok = data_i <= 16'h0002;
            PRM_OPSRC: value_ok = data_i <= OPS_EXTFREQ || data_i == OPS_SWITCH2;
            PRM_POLES: value_ok = data_i == 16'h0000 || poles_plain(data_i) ||
                poles_dual(data_i);
            default: value_ok = 1'b1;
        endcase
    end

    assign accept_o = allowed && value_ok;
endmodule // write_guard

// [drive_mode_ctrl.sv]
// Drive control and mode-select core with Wishbone registers
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/10ps
module drive_mode_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // Keypad parameter port
    input wire logic kp_wr_i,
    input wire logic [7:0] kp_num_i,
    input wire logic [15:0] kp_data_i,
    output logic kp_ack_o,
    output logic kp_refused_o,
    input wire logic keypad_unit_present_i,
    input wire logic kp_fwd_i,
    input wire logic kp_rev_i,
    input wire logic kp_jog_i,
    // External terminals
    input wire logic ext_reset_in_i,
    input wire logic fwd_run_in_i,
    input wire logic rev_run_in_i,
    input wire logic jog_in_i,
    input wire logic second_function_in_i,
    input wire logic [drive_pkg::REF_W-1:0] ref_in_i,
    // Drive state
    input wire logic running_i,
    input wire logic trip_i,
    input wire logic alarm_i,
    input wire logic [3:0] alarm_code_i,
    input wire logic [3:0] norm_status_i,
    // Drive commands
    output logic fwd_cmd_o,
    output logic rev_cmd_o,
    output logic jog_cmd_o,
    output logic freq_from_keypad_o,
    output logic [drive_pkg::REF_W-1:0] ref_filt_o,
    output logic output_off_o,
    output logic accum_clear_o,
    output logic coast_o,
    output logic trip_reset_o,
    output logic kp_err_o,
    output logic vector_mode_o,
    output logic second_accel_o,
    // Status outputs
    output logic up_to_speed_out_o,
    output logic power_fail_out_o,
    output logic overload_out_o,
    output logic freq_detect_out_o
);
    import drive_pkg::*;

    typedef struct packed {
        logic [PRM_CNT-1:0][PRM_W-1:0] prm;
        logic ext_sel;
        logic [EV_W-1:0] stat;
        logic [EV_W-1:0] mask;
        logic [31:0] dat;
        logic ack;
        logic irq;
        logic kp_ack;
        logic kp_ref;
        logic sec_lat;
        logic kp_err;
        logic [2:0] cmd;
        logic freq_kp;
        logic [REF_W-1:0] ref_q;
        logic off;
        logic acc_clr;
        logic coast;
        logic trip_rst;
        logic vec;
        logic sec_acc;
        logic [3:0] sts;
    } state_t;

    state_t s;
    state_t next_s;
    logic [REF_W-1:0] ref_f;
    logic accept;
    logic ext_mode;
    logic start_ext;
    logic freq_ext;
    logic rst_ok;
    logic rst_act;
    logic [7:0] widx;
    logic [EV_W-1:0] ev;
    logic [2:0] raw;
    logic [15:0] rsel;
    logic [15:0] asel;
    logic [15:0] dinh;
    logic [15:0] ops;
    logic [15:0] poles;
    logic bus_rd;
    logic bus_wr;

    // Reference filter with a time constant from parameter 74
    ref_filter u_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ref_i(ref_in_i),
        .shift_i(s.prm[0][3:0]),
        .ref_o(ref_f)
    );

    // Keypad write protection
    write_guard u_guard (
        .num_i(kp_num_i),
        .data_i(kp_data_i),
        .wprot_i(s.prm[3]),
        .running_i(running_i),
        .ext_mode_i(ext_mode),
        .accept_o(accept)
    );

    // Decoded settings and source selection
    always_comb begin
        rsel = s.prm[1];
        asel = s.prm[2];
        dinh = s.prm[4];
        ops = s.prm[5];
        poles = s.prm[7];
        widx = 8'(kp_num_i - PRM_FILT);
        ext_mode = ops == OPS_EXT ||
            ((ops == OPS_SWITCH || ops == OPS_SWITCH2) && s.ext_sel);
        start_ext = ext_mode || ops == OPS_KPFREQ;
        freq_ext = ext_mode || ops == OPS_EXTFREQ;
        rst_ok = !rsel[0] || trip_i;
        rst_act = ext_reset_in_i && rst_ok;
        raw = start_ext ? {jog_in_i, rev_run_in_i, fwd_run_in_i}
            : {kp_jog_i, kp_rev_i, kp_fwd_i};
        bus_rd = wb_cyc_i && wb_stb_i && !s.ack && !wb_we_i;
        bus_wr = wb_cyc_i && wb_stb_i && !s.ack && wb_we_i;
    end

    // Next state of the whole block
    always_comb begin
        next_s = s;
        ev = '0;
        // Keypad writes, refused ones leave the store alone
        next_s.kp_ack = kp_wr_i;
        next_s.kp_ref = kp_wr_i && !accept;
        if (kp_wr_i && accept && kp_num_i >= PRM_FILT && kp_num_i <= PRM_POLES) begin
            next_s.prm[widx[2:0]] = kp_data_i;
        end
        ev[EV_REFUSED] = kp_wr_i && !accept;
        // Keypad loss; a later accepted reset clears it
        if (rsel[1] && !keypad_unit_present_i) begin
            next_s.kp_err = 1'b1;
        end else if (rst_act) begin
            next_s.kp_err = 1'b0;
        end
        ev[EV_KP_LOSS] = rsel[1] && !keypad_unit_present_i && !s.kp_err;
        // Reset input effects
        next_s.off = rst_act || next_s.kp_err;
        next_s.acc_clr = rst_act;
        next_s.coast = rst_act && running_i;
        next_s.trip_rst = rst_act && trip_i;
        ev[EV_RESET] = rst_act && !s.acc_clr;
        // Forward and reverse commands gated by direction inhibit, whatever their source; jog only by output off
        next_s.cmd[0] = raw[0] && dinh != 16'h0002 && !next_s.off;
        next_s.cmd[1] = raw[1] && dinh != 16'h0001 && !next_s.off;
        next_s.cmd[2] = raw[2] && !next_s.off;
        ev[EV_DIR] = (raw[0] && dinh == 16'h0002) || (raw[1] && dinh == 16'h0001);
        next_s.freq_kp = !freq_ext;
        next_s.ref_q = ref_f;
        // Second function is taken only while stopped
        if (!running_i) begin
            next_s.sec_lat = second_function_in_i;
        end
        next_s.vec = poles_plain(poles) || (poles_dual(poles) && !s.sec_lat);
        next_s.sec_acc = poles_dual(poles) && s.sec_lat;
        // Status terminal multiplexer
        case (asel)
            16'h0001: next_s.sts = alarm_code_i;
            16'h0002: next_s.sts = alarm_i ? alarm_code_i : norm_status_i;
            default: next_s.sts = norm_status_i;
        endcase
        // Wishbone slave, one wait state, ack for one cycle
        next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
        next_s.dat = '0;
        if (bus_rd) begin
            case (wb_adr_i)
                REG_CTRL: next_s.dat[CTRL_EXT] = s.ext_sel;
                REG_STAT: next_s.dat[EV_W-1:0] = s.stat;
                REG_MASK: next_s.dat[EV_W-1:0] = s.mask;
                REG_STATE: next_s.dat[7:0] = {s.sec_acc, s.vec, s.kp_err, s.off,
                    start_ext, freq_ext, s.trip_rst, s.coast};
                default: begin
                    if (wb_adr_i >= REG_PRM && wb_adr_i[1:0] == 2'b00 &&
                        wb_adr_i < 8'(REG_PRM + 8'(PRM_CNT * 4))) begin
                        next_s.dat[15:0] = s.prm[wb_adr_i[4:2]];
                    end
                end
            endcase
        end
        if (bus_wr && wb_sel_i[0]) begin
            case (wb_adr_i)
                REG_CTRL: next_s.ext_sel = wb_dat_i[CTRL_EXT];
                REG_MASK: next_s.mask = wb_dat_i[EV_W-1:0];
                default: next_s.mask = s.mask;
            endcase
        end
        // Sticky events; a read clears, but a new event wins
        if (bus_rd && wb_adr_i == REG_STAT) begin
            next_s.stat = ev;
        end else begin
            next_s.stat = s.stat | ev;
        end
        next_s.irq = |(next_s.stat & next_s.mask);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.prm[0] <= RST_FILT;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state
    assign wb_dat_o = s.dat;
    assign wb_ack_o = s.ack;
    assign irq_o = s.irq;
    assign kp_ack_o = s.kp_ack;
    assign kp_refused_o = s.kp_ref;
    assign fwd_cmd_o = s.cmd[0];
    assign rev_cmd_o = s.cmd[1];
    assign jog_cmd_o = s.cmd[2];
    assign freq_from_keypad_o = s.freq_kp;
    assign ref_filt_o = s.ref_q;
    assign output_off_o = s.off;
    assign accum_clear_o = s.acc_clr;
    assign coast_o = s.coast;
    assign trip_reset_o = s.trip_rst;
    assign kp_err_o = s.kp_err;
    assign vector_mode_o = s.vec;
    assign second_accel_o = s.sec_acc;
    assign up_to_speed_out_o = s.sts[3];
    assign power_fail_out_o = s.sts[2];
    assign overload_out_o = s.sts[1];
    assign freq_detect_out_o = s.sts[0];

    // Checks next to the logic
    a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    a_refused_keeps_value: assert property (@(posedge clk_i) disable iff (rst_i)
        kp_refused_o |-> s.prm == $past(s.prm)) else $error("refused write stored");
    a_refused_when_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        (kp_wr_i && s.prm[3] == 16'h0001 && kp_num_i == PRM_DIRINH && !ext_mode)
        |=> kp_ack_o && kp_refused_o) else $error("locked write taken");
    a_stop_only_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (kp_wr_i && s.prm[3] == 16'h0000 && running_i && kp_num_i == PRM_ALMSEL)
        |=> kp_refused_o) else $error("write while running");
    a_monitor_any_time: assert property (@(posedge clk_i) disable iff (rst_i)
        (kp_wr_i && kp_num_i >= PRM_MON_LO && kp_num_i <= PRM_MON_HI && !ext_mode)
        |=> !kp_refused_o)
        else $error("monitor write refused");
    a_no_reverse_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(dinh) == 16'h0001 |-> !rev_cmd_o) else $error("reverse not blocked");
    a_no_forward_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(dinh) == 16'h0002 |-> !fwd_cmd_o) else $error("forward not blocked");
    a_reset_hold_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (ext_reset_in_i && !rsel[0] && running_i) |=> output_off_o && accum_clear_o && coast_o)
        else $error("reset did not shut off");
    a_reset_gated_trip: assert property (@(posedge clk_i) disable iff (rst_i)
        (rsel[0] && !trip_i) |=> !accum_clear_o) else $error("reset taken without trip");
    a_keypad_loss_err: assert property (@(posedge clk_i) disable iff (rst_i)
        (rsel[1] && !keypad_unit_present_i) |=> kp_err_o ##0 output_off_o)
        else $error("keypad loss missed");
    a_alarm_code_out: assert property (@(posedge clk_i) disable iff (rst_i)
        asel == 16'h0001 |=> {up_to_speed_out_o, power_fail_out_o, overload_out_o,
        freq_detect_out_o} == $past(alarm_code_i)) else $error("alarm code wrong");
    // A status read with no new event must drop the interrupt on the next cycle
    a_irq_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_rd && wb_adr_i == REG_STAT && ev == '0) |=> !irq_o)
        else $error("irq not cleared by read");
endmodule // drive_mode_ctrl

// [keypad_model.sv]
// Keypad unit model: parameter writes and key panel
`timescale 1ns/10ps
module keypad_model (
    // Clock
    input wire logic clk_i,
    // Answer from the drive
    input wire logic kp_ack_i,
    input wire logic kp_refused_i,
    // Write request
    output logic kp_wr_o,
    output logic [7:0] kp_num_o,
    output logic [15:0] kp_data_o,
    // Key panel
    output logic present_o,
    output logic fwd_o,
    output logic rev_o,
    output logic jog_o
);
    // Connected and idle at start
    initial begin
        kp_wr_o = 1'b0;
        kp_num_o = 8'h00;
        kp_data_o = 16'h0000;
        present_o = 1'b1;
        {fwd_o, rev_o, jog_o} = 3'b000;
    end
    // Key and cable levels, changed just after an edge
    task automatic keys(input logic f, input logic r, input logic j);
        {fwd_o, rev_o, jog_o} <= {f, r, j};
    endtask
    task automatic plug(input logic p);
        present_o <= p;
    endtask
    // One write; number and value are inverted afterwards so a late sample shows
    task automatic write(input logic [7:0] num, input logic [15:0] data,
                         output logic refused, output bit late);
        int n;
        kp_wr_o <= 1'b1;
        kp_num_o <= num;
        kp_data_o <= data;
        @(posedge clk_i);
        kp_wr_o <= 1'b0;
        kp_num_o <= ~num;
        kp_data_o <= ~data;
        n = 0;
        while (kp_ack_i !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            n++;
        end
        refused = kp_refused_i;
        late = (n >= 8);
    endtask
endmodule // keypad_model

// [drive_mode_ctrl_test.sv]
// Self-checking bench for the drive mode-select core
`timescale 1ns/10ps
module drive_mode_ctrl_test;
    import drive_pkg::*;
    // Design connections
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic [7:0] wb_adr_i, kp_num_i;
    logic [3:0] wb_sel_i, alarm_code_i, norm_status_i, st;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic kp_wr_i, kp_ack_o, kp_refused_o, keypad_unit_present_i, kp_fwd_i, kp_rev_i, kp_jog_i;
    logic [15:0] kp_data_i;
    logic ext_reset_in_i, fwd_run_in_i, rev_run_in_i, jog_in_i, second_function_in_i;
    logic [REF_W-1:0] ref_in_i, ref_filt_o;
    logic running_i, trip_i, alarm_i, fwd_cmd_o, rev_cmd_o, jog_cmd_o, freq_from_keypad_o;
    logic output_off_o, accum_clear_o, coast_o, trip_reset_o, kp_err_o, vector_mode_o;
    logic second_accel_o, up_to_speed_out_o, power_fail_out_o, overload_out_o, freq_detect_out_o;
    int fails, comparisons;

    drive_mode_ctrl DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .kp_wr_i, .kp_num_i, .kp_data_i, .kp_ack_o,
        .kp_refused_o, .keypad_unit_present_i, .kp_fwd_i, .kp_rev_i, .kp_jog_i, .ext_reset_in_i,
        .fwd_run_in_i, .rev_run_in_i, .jog_in_i, .second_function_in_i, .ref_in_i, .running_i,
        .trip_i, .alarm_i, .alarm_code_i, .norm_status_i, .fwd_cmd_o, .rev_cmd_o, .jog_cmd_o,
        .freq_from_keypad_o, .ref_filt_o, .output_off_o, .accum_clear_o, .coast_o,
        .trip_reset_o, .kp_err_o, .vector_mode_o, .second_accel_o, .up_to_speed_out_o,
        .power_fail_out_o, .overload_out_o, .freq_detect_out_o);
    keypad_model kp (.clk_i, .kp_ack_i(kp_ack_o), .kp_refused_i(kp_refused_o),
        .kp_wr_o(kp_wr_i), .kp_num_o(kp_num_i), .kp_data_o(kp_data_i),
        .present_o(keypad_unit_present_i), .fwd_o(kp_fwd_i), .rev_o(kp_rev_i), .jog_o(kp_jog_i));
    assign st = {up_to_speed_out_o, power_fail_out_o, overload_out_o, freq_detect_out_o};

    // 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic finish_test;
        if (fails == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Outputs lag inputs by one edge; three edges leave margin for parameter paths
    task automatic settle;
        repeat (3) @(posedge clk_i);
    endtask
    // Classic Wishbone cycle; waits for ack under a bound
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            finish_test();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(a, 1'b0, 32'h0, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask
    function automatic logic [7:0] padr(input logic [7:0] n);
        return REG_PRM + ((n - PRM_FILT) << 2);
    endfunction
    // Keypad write; refusal flag judged, stored value too for parameters 74 to 81
    task automatic kp_set(input logic [7:0] n, input logic [15:0] d, input logic refd);
        logic [31:0] old, now;
        logic r;
        bit late;
        old = 32'h0;
        if (n >= PRM_FILT && n <= PRM_POLES) rd(padr(n), old);
        kp.write(n, d, r, late);
        if (late) begin
            fails++;
            finish_test();
        end
        check(r, refd);
        if (n >= PRM_FILT && n <= PRM_POLES) begin
            rd(padr(n), now);
            check(now, refd ? old : {16'h0, d});
        end
    endtask

    task automatic t_regs;
        logic [31:0] q;
        for (int n = 74; n <= 81; n++) begin
            rd(padr(8'(n)), q);
            check(q, (n == 74) ? 32'h1 : 32'h0);
        end
        wr(8'h10, 32'h0000_00FF);
        rd(8'h10, q);
        check(q, 32'h0);
        // Lane 0 not selected, so the mask write must be ignored
        wb_sel_i <= 4'h0;
        wr(REG_MASK, 32'h0000_000F);
        wb_sel_i <= 4'h1;
        rd(REG_MASK, q);
        check(q, 32'h0);
    endtask
    task automatic t_filter;
        ref_in_i <= 12'h800;
        repeat (260) @(posedge clk_i);
        check(ref_filt_o > 0 && ref_filt_o < 12'h800, 1);
        repeat (10000) @(posedge clk_i);
        check(ref_filt_o >= 12'h7F0, 1);
        kp_set(PRM_FILT, 16'h4, 0);
        ref_in_i <= 12'h000;
        repeat (260) @(posedge clk_i);
        check(ref_filt_o > 12'h600, 1);
    endtask
    task automatic t_protect;
        running_i <= 1'b1;
        settle();
        kp_set(PRM_ALMSEL, 16'h1, 1);
        kp_set(PRM_MON_LO, 16'h5, 0);
        running_i <= 1'b0;
        settle();
        kp_set(PRM_ALMSEL, 16'h2, 0);
        kp_set(PRM_WPROT, 16'h1, 0);
        kp_set(PRM_DIRINH, 16'h1, 1);
        kp_set(PRM_OPSRC, OPS_KEYPAD, 0);
        kp_set(PRM_OPSRC, OPS_SWITCH, 0);
        kp_set(PRM_WPROT, 16'h2, 0);
        running_i <= 1'b1;
        settle();
        kp_set(PRM_DIRINH, 16'h2, 0);
        kp_set(PRM_OPSRC, OPS_KEYPAD, 1);
        kp_set(PRM_POLES, 16'h2, 1);
        kp_set(PRM_MCAP, 16'h1, 1);
        kp_set(PRM_DIRINH, 16'h0, 0);
        running_i <= 1'b0;
        settle();
        kp_set(PRM_WPROT, 16'h0, 0);
    endtask
    task automatic t_alarm;
        norm_status_i <= 4'hA;
        alarm_code_i <= 4'h5;
        kp_set(PRM_ALMSEL, 16'h0, 0);
        settle();
        check(st, 4'hA);
        kp_set(PRM_ALMSEL, 16'h1, 0);
        settle();
        check(st, 4'h5);
        kp_set(PRM_ALMSEL, 16'h2, 0);
        settle();
        check(st, 4'hA);
        alarm_i <= 1'b1;
        settle();
        check(st, 4'h5);
        alarm_i <= 1'b0;
    endtask
    task automatic t_direction;
        for (int s = 0; s <= 2; s++) begin
            kp_set(PRM_DIRINH, 16'(s), 0);
            kp.keys(1, 0, 0);
            settle();
            check(fwd_cmd_o, s != 2);
            kp.keys(0, 1, 0);
            settle();
            check(rev_cmd_o, s != 1);
        end
        kp.keys(0, 0, 0);
        kp_set(PRM_OPSRC, OPS_EXT, 0);
        fwd_run_in_i <= 1'b1;
        settle();
        check(fwd_cmd_o, 0);
        fwd_run_in_i <= 1'b0;
        rev_run_in_i <= 1'b1;
        settle();
        check(rev_cmd_o, 1);
        rev_run_in_i <= 1'b0;
        kp.keys(0, 1, 0);
        settle();
        check(rev_cmd_o, 0);
        kp.keys(0, 0, 0);
        kp_set(PRM_DIRINH, 16'h0, 1);
        kp_set(PRM_OPSRC, OPS_KEYPAD, 0);
        kp_set(PRM_DIRINH, 16'h0, 0);
        fwd_run_in_i <= 1'b1;
        settle();
        check(fwd_cmd_o, 0);
        fwd_run_in_i <= 1'b0;
    endtask
    task automatic t_source;
        kp_set(PRM_OPSRC, OPS_KPFREQ, 0);
        jog_in_i <= 1'b1;
        kp.keys(1, 0, 0);
        settle();
        check({freq_from_keypad_o, jog_cmd_o, fwd_cmd_o}, 3'b110);
        jog_in_i <= 1'b0;
        kp_set(PRM_OPSRC, OPS_EXTFREQ, 0);
        kp.keys(0, 0, 1);
        rev_run_in_i <= 1'b1;
        settle();
        check({freq_from_keypad_o, jog_cmd_o, rev_cmd_o}, 3'b010);
        rev_run_in_i <= 1'b0;
        kp.keys(0, 0, 0);
        kp_set(PRM_OPSRC, OPS_SWITCH, 0);
        wr(REG_CTRL, 32'h1);
        kp_set(PRM_DIRINH, 16'h1, 1);
        wr(REG_CTRL, 32'h0);
    endtask
    task automatic t_reset;
        logic [31:0] q;
        kp_set(PRM_RSTSEL, 16'h1, 0);
        ext_reset_in_i <= 1'b1;
        settle();
        check(trip_reset_o, 0);
        trip_i <= 1'b1;
        settle();
        check(trip_reset_o, 1);
        trip_i <= 1'b0;
        kp_set(PRM_RSTSEL, 16'h0, 0);
        running_i <= 1'b1;
        settle();
        check({trip_reset_o, output_off_o, accum_clear_o, coast_o}, 4'h7);
        ext_reset_in_i <= 1'b0;
        running_i <= 1'b0;
        kp.plug(0);
        settle();
        check(kp_err_o, 0);
        kp.plug(1);
        kp_set(PRM_RSTSEL, 16'h2, 0);
        rd(REG_STAT, q);
        wr(REG_MASK, 32'h1 << EV_KP_LOSS);
        kp.plug(0);
        settle();
        check({kp_err_o, output_off_o, irq_o}, 3'b111);
        kp.plug(1);
        rd(REG_STAT, q);
        check(q[EV_KP_LOSS], 1);
        settle();
        check(irq_o, 0);
        wr(REG_MASK, 32'h0);
        kp.plug(0);
        settle();
        check(irq_o, 0);
        kp.plug(1);
        ext_reset_in_i <= 1'b1;
        settle();
        ext_reset_in_i <= 1'b0;
        settle();
        check(kp_err_o, 0);
        kp_set(PRM_RSTSEL, 16'h0, 0);
    endtask
    task automatic t_poles;
        int pl[3] = '{12, 14, 16};
        kp_set(PRM_POLES, 16'h2, 0);
        kp_set(PRM_POLES, 16'h3, 1);
        kp_set(PRM_POLES, 16'h6, 0);
        settle();
        check(vector_mode_o, 1);
        foreach (pl[i]) begin
            kp_set(PRM_POLES, 16'(pl[i]), 0);
            second_function_in_i <= 1'b1;
            settle();
            check({vector_mode_o, second_accel_o}, 2'b01);
            running_i <= 1'b1;
            second_function_in_i <= 1'b0;
            settle();
            check(vector_mode_o, 0);
            running_i <= 1'b0;
            settle();
            check(vector_mode_o, 1);
        end
    endtask

    // Main sequence: idle inputs, two-cycle reset, then each scenario
    initial begin
        fails = 0;
        comparisons = 0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, ext_reset_in_i, fwd_run_in_i, rev_run_in_i} = 6'h0;
        {jog_in_i, second_function_in_i, running_i, trip_i, alarm_i} = 5'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0;
        ref_in_i = 12'h000;
        alarm_code_i = 4'h0;
        norm_status_i = 4'h0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_filter();
        t_protect();
        t_alarm();
        t_direction();
        t_source();
        t_reset();
        t_poles();
        finish_test();
    end
endmodule // drive_mode_ctrl_test
